/* File: logic/isolated_octal_output_latch_ctrl.sv */
// control logic of an isolated eight channel output switch
`timescale 1ns/100ps
`include "octal_latch_cfg.svh"
module isolated_octal_output_latch_ctrl
    import octal_latch_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic outputs_kill_n,
    input wire logic select_n,
    input wire logic load_n,
    input wire logic [7:0] channel_cmd_bits,
    input wire logic [7:0] channel_overtemp,
    input wire logic load_supply_low,
    input wire logic link_xfer_strobe,
    input wire logic link_xfer_valid,
    output logic [7:0] switch_channel_out,
    output logic overtemp_alarm_n,
    output logic overtemp_alarm_oe
);
    // three-stage input synchronisers
    logic [2:0] kill_s1_q, kill_s1_d;
    logic [2:0] sel_s1_q, sel_s1_d;
    logic [2:0] load_s1_q, load_s1_d;
    logic [7:0] dat_s1_q, dat_s1_d, dat_s2_q, dat_s2_d, dat_s3_q, dat_s3_d;
    logic kill_n_q, kill_n_d, sel_n_q, sel_n_d, load_n_q, load_n_d;
    logic [7:0] dat_q, dat_d;
    logic [7:0] in_latch_q, in_latch_d;
    logic [7:0] out_buf_q, out_buf_d;
    logic armed_q, armed_d;
    logic [7:0] out_q, out_d;
    logic alarm_n_q, alarm_n_d;
    logic [10:0] stable_cnt_q, stable_cnt_d;
    link_state_t link_q, link_d;
    logic [2:0] rej_q, rej_d;
    logic [7:0] pwm_q, pwm_d;
    logic direct;
    logic [7:0] hot_off;
    logic alarm_oe_q, alarm_oe_d;

    always_comb begin
        kill_s1_d = {kill_s1_q[1:0], outputs_kill_n};
        sel_s1_d = {sel_s1_q[1:0], select_n};
        load_s1_d = {load_s1_q[1:0], load_n};
        dat_s1_d = channel_cmd_bits;
        dat_s2_d = dat_s1_q;
        dat_s3_d = dat_s2_q;
        kill_n_d = (kill_s1_q[2] == kill_s1_q[1]) ? kill_s1_q[1] : kill_n_q;
        sel_n_d = (sel_s1_q[2] == sel_s1_q[1]) ? sel_s1_q[1] : sel_n_q;
        load_n_d = (load_s1_q[2] == load_s1_q[1]) ? load_s1_q[1] : load_n_q;
    end

    // per-bit settle filter on the data lines
    for (genvar g = 0; g < `CHAN_COUNT; g++) begin : g_dat
        assign dat_d[g] = (dat_s3_q[g] == dat_s2_q[g]) ? dat_s2_q[g]
            : dat_q[g];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            kill_s1_q <= 3'h0;
            sel_s1_q <= 3'h7;
            load_s1_q <= 3'h7;
            dat_s1_q <= 8'h00;
            dat_s2_q <= 8'h00;
            dat_s3_q <= 8'h00;
            kill_n_q <= 1'h0;
            sel_n_q <= 1'h1;
            load_n_q <= 1'h1;
            dat_q <= 8'h00;
        end else begin
            kill_s1_q <= kill_s1_d;
            sel_s1_q <= sel_s1_d;
            load_s1_q <= load_s1_d;
            dat_s1_q <= dat_s1_d;
            dat_s2_q <= dat_s2_d;
            dat_s3_q <= dat_s3_d;
            kill_n_q <= kill_n_d;
            sel_n_q <= sel_n_d;
            load_n_q <= load_n_d;
            dat_q <= dat_d;
        end
    end

    assign direct = !sel_n_q && !load_n_q;

    // write path: input latches, output buffer, kill
    always_comb begin
        in_latch_d = in_latch_q;
        out_buf_d = out_buf_q;
        armed_d = armed_q;
        if (!sel_n_q && !load_n_q) begin
            in_latch_d = dat_q;
            armed_d = 1'b1;
        end
        // select rise copies the held input latch value into the output buffer
        if (!sel_n_q && sel_n_d) begin
            out_buf_d = in_latch_q;
        end
        if (!kill_n_q) begin
            in_latch_d = `LATCH_RESET;
            out_buf_d = `LATCH_RESET;
            armed_d = 1'b0;
        end
    end

    // link check on received transfers
    always_comb begin
        link_d = link_q;
        rej_d = rej_q;
        stable_cnt_d = stable_cnt_q;
        case (link_q)
            st_wait: begin
                if (stable_cnt_q == 11'(`STABLE_CYCLES)) begin
                    link_d = st_run;
                end else begin
                    stable_cnt_d = stable_cnt_q + 11'h001;
                end
            end
            st_run: begin
                if (link_xfer_strobe && !link_xfer_valid) begin
                    rej_d = rej_q + 3'h1;
                    if (rej_q + 3'h1 == `REJECT_LIMIT) begin
                        link_d = st_mute;
                        rej_d = 3'h0;
                    end
                end else if (link_xfer_strobe) begin
                    rej_d = 3'h0;
                end
            end
            st_mute: begin
                if (link_xfer_strobe && link_xfer_valid) begin
                    link_d = st_run;
                end
            end
            default: begin
                link_d = st_wait;
            end
        endcase
    end

    // output stage with thermal duty pattern
    always_comb begin
        pwm_d = (pwm_q == `PWM_PERIOD_CYCLES) ? 8'h00 : pwm_q + 8'h01;
        out_d = 8'h00;
        if (link_q == st_run && kill_n_q && armed_q) begin
            out_d = direct ? dat_q : out_buf_q;
        end
        out_d = out_d & ~hot_off;
        alarm_n_d = !(|channel_overtemp || load_supply_low);
        alarm_oe_d = |channel_overtemp || load_supply_low;
    end

    // hot channels stay off outside the short on window of the pattern
    for (genvar g = 0; g < `CHAN_COUNT; g++) begin : g_hot
        assign hot_off[g] = channel_overtemp[g] && pwm_q >= `PWM_ON_CYCLES;
        property p_hot_duty;
            @(posedge clock) disable iff (rst)
            (channel_overtemp[g] && pwm_q >= `PWM_ON_CYCLES)
                |=> !switch_channel_out[g];
        endproperty
        a_hot_duty: assert property (p_hot_duty)
            else $error("hot channel on outside its duty window");
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            in_latch_q <= `LATCH_RESET;
            out_buf_q <= `LATCH_RESET;
            armed_q <= 1'b0;
            link_q <= st_wait;
            rej_q <= 3'h0;
            stable_cnt_q <= 11'h000;
            pwm_q <= 8'h00;
            out_q <= 8'h00;
            alarm_n_q <= 1'b1;
            alarm_oe_q <= 1'b0;
        end else begin
            in_latch_q <= in_latch_d;
            out_buf_q <= out_buf_d;
            armed_q <= armed_d;
            link_q <= link_d;
            rej_q <= rej_d;
            stable_cnt_q <= stable_cnt_d;
            pwm_q <= pwm_d;
            out_q <= out_d;
            alarm_n_q <= alarm_n_d;
            alarm_oe_q <= alarm_oe_d;
        end
    end

    assign switch_channel_out = out_q;
    assign overtemp_alarm_n = alarm_n_q;
    assign overtemp_alarm_oe = alarm_oe_q;

    property p_kill_off;
        @(posedge clock) disable iff (rst)
        !kill_n_q |=> switch_channel_out == 8'h00;
    endproperty
    a_kill_off: assert property (p_kill_off)
        else $error("outputs on during kill");

    property p_kill_clear;
        @(posedge clock) disable iff (rst)
        !kill_n_q |=> in_latch_q == 8'h00 && out_buf_q == 8'h00;
    endproperty
    a_kill_clear: assert property (p_kill_clear)
        else $error("latches not cleared by kill");

    property p_stay_off;
        @(posedge clock) disable iff (rst)
        !armed_q |=> switch_channel_out == 8'h00;
    endproperty
    a_stay_off: assert property (p_stay_off)
        else $error("output on before new write");

    property p_follow;
        @(posedge clock) disable iff (rst)
        (!sel_n_q && !load_n_q && kill_n_q) |=> in_latch_q == $past(dat_q);
    endproperty
    a_follow: assert property (p_follow)
        else $error("input latch not following data");

    property p_hold;
        @(posedge clock) disable iff (rst)
        (load_n_q && kill_n_q) |=> $stable(in_latch_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("input latch changed while load high");

    property p_copy;
        @(posedge clock) disable iff (rst)
        (!sel_n_q && sel_n_d && kill_n_q) |=> out_buf_q == $past(in_latch_q);
    endproperty
    a_copy: assert property (p_copy)
        else $error("output buffer not loaded on select rise");

    property p_wait_off;
        @(posedge clock) disable iff (rst)
        link_q == st_wait |=> switch_channel_out == 8'h00;
    endproperty
    a_wait_off: assert property (p_wait_off)
        else $error("outputs on before input side stable");

    property p_alarm;
        @(posedge clock) disable iff (rst)
        (|channel_overtemp || load_supply_low)
            |=> !overtemp_alarm_n && overtemp_alarm_oe;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm not asserted");

    property p_mute;
        @(posedge clock) disable iff (rst)
        link_q == st_mute |=> switch_channel_out == 8'h00;
    endproperty
    a_mute: assert property (p_mute)
        else $error("outputs on while link muted");

    property p_disarm;
        @(posedge clock) disable iff (rst)
        !kill_n_q |=> !armed_q;
    endproperty
    a_disarm: assert property (p_disarm)
        else $error("outputs still armed after kill");

    property p_direct;
        @(posedge clock) disable iff (rst)
        (direct && link_q == st_run && kill_n_q && armed_q
            && !(|channel_overtemp))
            |=> switch_channel_out == $past(dat_q);
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct mode output not following data");

    property p_latched;
        @(posedge clock) disable iff (rst)
        (!direct && link_q == st_run && kill_n_q && armed_q
            && !(|channel_overtemp))
            |=> switch_channel_out == $past(out_buf_q);
    endproperty
    a_latched: assert property (p_latched)
        else $error("outputs not driven from output buffer");

    property p_wait_hold;
        @(posedge clock) disable iff (rst)
        (link_q == st_wait && stable_cnt_q != 11'(`STABLE_CYCLES))
            |=> link_q == st_wait;
    endproperty
    a_wait_hold: assert property (p_wait_hold)
        else $error("output stage enabled before settle time");

    property p_fourth_reject;
        @(posedge clock) disable iff (rst)
        (link_q == st_run && link_xfer_strobe && !link_xfer_valid
            && rej_q == `REJECT_LIMIT - 3'h1) |=> link_q == st_mute;
    endproperty
    a_fourth_reject: assert property (p_fourth_reject)
        else $error("fourth rejected transfer did not mute");

    property p_resume;
        @(posedge clock) disable iff (rst)
        (link_q == st_mute && link_xfer_strobe && link_xfer_valid)
            |=> link_q == st_run;
    endproperty
    a_resume: assert property (p_resume)
        else $error("valid transfer did not end mute");

    property p_alarm_clear;
        @(posedge clock) disable iff (rst)
        !(|channel_overtemp || load_supply_low)
            |=> overtemp_alarm_n && !overtemp_alarm_oe;
    endproperty
    a_alarm_clear: assert property (p_alarm_clear)
        else $error("alarm asserted with no fault");
endmodule

/* File: logic/octal_latch_cfg.svh */
// timing counts and reset values for the octal output latch control
`ifndef OCTAL_LATCH_CFG_SVH
`define OCTAL_LATCH_CFG_SVH
`define CHAN_COUNT 8
`define LATCH_RESET 8'h00
`define REJECT_LIMIT 3'h4
`define STABLE_TIME_NS 1000
`define STABLE_CYCLES (((`STABLE_TIME_NS) + 9) / 10)
`define PWM_ON_CYCLES 8'h0F
`define PWM_PERIOD_CYCLES 8'hFF
`endif

/* File: logic/octal_latch_pkg.sv */
// types for the octal output latch control
package octal_latch_pkg;
    typedef enum logic [2:0] {
        st_wait = 3'b001,
        st_run = 3'b010,
        st_mute = 3'b100
    } link_state_t;
endpackage

/* File: tb/host_port_model.sv */
// host port pin model driving the strobes and data lines
`timescale 1ns/100ps
module host_port_model (
    input wire logic clock,
    output logic select_n,
    output logic load_n,
    output logic [7:0] channel_cmd_bits
);
    initial begin
        select_n = 1'b1;
        load_n = 1'b1;
        channel_cmd_bits = 8'h00;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    // select stays low across the whole write
    task automatic write_byte(input logic [7:0] b);
        @(posedge clock);
        select_n <= 1'b0;
        hold(6);
        load_n <= 1'b0;
        channel_cmd_bits <= b;
        hold(6);
        load_n <= 1'b1;
        hold(6);
        channel_cmd_bits <= ~b;
        hold(6);
        select_n <= 1'b1;
        hold(6);
    endtask
    task automatic direct(input logic [7:0] b);
        select_n <= 1'b0;
        load_n <= 1'b0;
        channel_cmd_bits <= b;
        hold(6);
    endtask
endmodule

/* File: tb/isolated_octal_output_latch_ctrl_tb.sv */
// self-checking bench for the octal output latch control
`timescale 1ns/100ps
module isolated_octal_output_latch_ctrl_tb;
    logic clock, rst, outputs_kill_n, load_supply_low;
    logic link_xfer_strobe, link_xfer_valid, select_n, load_n;
    logic [7:0] channel_cmd_bits, channel_overtemp, switch_channel_out;
    logic [7:0] b;
    logic overtemp_alarm_n, overtemp_alarm_oe;
    logic [9:0] exp_q[$];
    logic [9:0] e;
    int mismatches = 0;
    int n_compared = 0;
    int k;
    isolated_octal_output_latch_ctrl isolated_octal_output_latch_ctrl_i (
        .clock(clock), .rst(rst), .outputs_kill_n(outputs_kill_n),
        .select_n(select_n), .load_n(load_n),
        .channel_cmd_bits(channel_cmd_bits),
        .channel_overtemp(channel_overtemp),
        .load_supply_low(load_supply_low),
        .link_xfer_strobe(link_xfer_strobe),
        .link_xfer_valid(link_xfer_valid),
        .switch_channel_out(switch_channel_out),
        .overtemp_alarm_n(overtemp_alarm_n),
        .overtemp_alarm_oe(overtemp_alarm_oe));
    host_port_model host_port_model_i (.clock(clock), .select_n(select_n),
        .load_n(load_n), .channel_cmd_bits(channel_cmd_bits));
    function automatic logic [9:0] seen();
        return {overtemp_alarm_oe, overtemp_alarm_n, switch_channel_out};
    endfunction
    task automatic check(input logic [9:0] x, input logic [9:0] y);
        n_compared++;
        if (x !== y) begin
            mismatches++;
            $display("MISMATCH oe_alarm_out expected %h seen %h", x, y);
        end
    endtask
    task automatic want(input logic [9:0] x);
        int j;
        exp_q.push_back(x);
        for (j = 0; j < 60 && exp_q.size() > 0; j++) @(posedge clock);
        if (exp_q.size() > 0) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic link(input logic v);
        @(posedge clock);
        link_xfer_strobe <= 1'b1;
        link_xfer_valid <= v;
        @(posedge clock);
        link_xfer_strobe <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // oldest note against the outputs once they settle, bounded
    always begin
        @(negedge clock);
        if (exp_q.size() > 0) begin
            e = exp_q[0];
            for (k = 0; k < 40 && seen() !== e; k++) @(negedge clock);
            check(e, seen());
            void'(exp_q.pop_front());
            if (k == 40) test_done();
        end
    end
    initial begin
        rst = 1'b1;
        outputs_kill_n = 1'b1;
        load_supply_low = 1'b0;
        link_xfer_strobe = 1'b0;
        link_xfer_valid = 1'b0;
        channel_overtemp = 8'h00;
        b = 8'($urandom(32'h1BAA30FC));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        host_port_model_i.direct(8'hFF);
        want(10'h100);
        repeat (120) @(posedge clock);
        link(1'b1);
        want(10'h1FF);
        $display("test direct done");
        b = 8'($urandom) | 8'h01;
        host_port_model_i.write_byte(b);
        want({2'b01, b});
        $display("test latched write done");
        outputs_kill_n <= 1'b0;
        want(10'h100);
        outputs_kill_n <= 1'b1;
        repeat (20) @(posedge clock);
        want(10'h100);
        b = 8'($urandom) | 8'h01;
        host_port_model_i.write_byte(b);
        want({2'b01, b});
        $display("test kill done");
        repeat (3) link(1'b0);
        want({2'b01, b});
        link(1'b0);
        want(10'h100);
        link(1'b1);
        want({2'b01, b});
        $display("test link done");
        host_port_model_i.write_byte(8'hFF);
        b = 8'h01 << ($urandom % 8);
        channel_overtemp <= b;
        want({2'b10, ~b});
        channel_overtemp <= 8'h00;
        want(10'h1FF);
        load_supply_low <= 1'b1;
        want(10'h2FF);
        load_supply_low <= 1'b0;
        want(10'h1FF);
        $display("test alarm done");
        test_done();
    end
endmodule
